// ==== adc_cfg.svh ====
// Purpose: Offsets, field positions, reset values and timing of the converter control.
// Assumes: Byte addresses on a 32-bit Avalon-MM bus.
// Notes: Definitions only.
`ifndef ADC_CFG_SVH
`define ADC_CFG_SVH

// ------------------------------------------------------------
// Register map
// ------------------------------------------------------------
`define ADC_CONTROL_ADDR 32'h1580_0000
`define ADC_RESULT_ADDR 32'h1580_0004
`define ADC_IRQ_STATUS_ADDR 32'h1580_0008
`define ADC_IRQ_ENABLE_ADDR 32'h1580_000c
`define ADC_IRQ_CLEAR_ADDR 32'h1580_0010

// ------------------------------------------------------------
// Control fields
// ------------------------------------------------------------
`define ADC_START_BIT 0
`define ADC_READ_START_BIT 1
`define ADC_STANDBY_BIT 2
`define ADC_CHANNEL_LSB 3
`define ADC_PRESC_VALUE_LSB 6
`define ADC_PRESC_ENABLE_BIT 14
`define ADC_EOC_BIT 15
`define ADC_CONTROL_RESET 16'h3fc4
`define ADC_PRESC_RESET 8'hff
`define ADC_STANDBY_RESET 1'h1
`define ADC_IRQ_EOC_BIT 0

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define ADC_CONV_CYCLES 5
`define ADC_CONV_CLK_MAX_KHZ 2500
`define ADC_BUS_CLK_KHZ 25000
`define ADC_MIN_DIVIDER ((`ADC_BUS_CLK_KHZ + `ADC_CONV_CLK_MAX_KHZ - 1) / `ADC_CONV_CLK_MAX_KHZ)

`endif

// ==== adc_pkg.sv ====
// Purpose: Types shared by the converter control modules.
// Assumes: Nothing beyond the config header.
// Notes: None.
`default_nettype none
package adc_pkg;

    typedef enum {CONV_IDLE, CONV_RUN} conv_state_t;

    typedef struct packed {
        logic presc_enable;
        logic [7:0] presc_value;
        logic [2:0] channel;
        logic standby;
        logic read_start;
    } ctrl_t;

    typedef struct packed {
        logic sample;
        logic busy;
        logic standby;
        logic tick;
        logic [2:0] channel;
    } core_ctrl_t;

endpackage
`default_nettype wire

// ==== adc_prescaler.sv ====
// Purpose: Converter clock divider producing one tick every N+1 bus clocks.
// Assumes: Same clock as the register logic.
// Notes: Value zero divides by one.
`timescale 1ns/1ps
`default_nettype none
module adc_prescaler #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    input wire logic clock_enable,
    // Control
    input wire logic enable,
    input wire logic [WIDTH-1:0] value,
    // Converter clock tick
    output logic tick_q
);
    logic [WIDTH-1:0] count_q;
    wire wrap = (count_q >= value);

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            count_q <= '0;
            tick_q <= 1'b0;
        end
        else if (clock_enable)
        begin
            count_q <= (!enable || wrap) ? '0 : count_q + 1'b1;
            tick_q <= enable && wrap;
        end
    end

    AST_NO_TICK_DISABLED: assert property (@(posedge clock) disable iff (reset)
        clock_enable && !enable |=> !tick_q)
        else $error("converter tick while prescaler disabled");
endmodule
`default_nettype wire

// ==== adc_irq.sv ====
// Purpose: Sticky event status, enable mask and level interrupt.
// Assumes: Clear register is write-one-to-clear.
// Notes: A set in the clearing cycle wins.
`timescale 1ns/1ps
`default_nettype none
module adc_irq #(
    parameter int N = 1
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    input wire logic clock_enable,
    // Events and software access
    input wire logic [N-1:0] event_set,
    input wire logic enable_we,
    input wire logic clear_we,
    input wire logic [N-1:0] wdata,
    // State
    output logic [N-1:0] status_q,
    output logic [N-1:0] enable_q,
    output logic irq_q
);
    wire [N-1:0] status_d = event_set | (status_q & ~(clear_we ? wdata : '0));

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            status_q <= '0;
            enable_q <= '0;
            irq_q <= 1'b0;
        end
        else if (clock_enable)
        begin
            status_q <= status_d;
            if (enable_we)
                enable_q <= wdata;
            irq_q <= |(status_d & (enable_we ? wdata : enable_q));
        end
    end

    AST_EVENT_STICKS: assert property (@(posedge clock) disable iff (reset)
        clock_enable && |event_set |=> (status_q & $past(event_set)) == $past(event_set))
        else $error("event not captured in status");
endmodule
`default_nettype wire

// ==== adc_conversion_control.sv ====
// Purpose: Register interface and sequencing of an eight-input 10-bit converter.
// Assumes: Analog core runs on this clock; result valid at the fifth tick.
// Notes: Registers over Avalon-MM with waitrequest; one wait state per access.
`timescale 1ns/1ps
`default_nettype none
`include "adc_cfg.svh"
module adc_conversion_control #(
    parameter int DATA_WIDTH = 10,
    parameter int CONV_CYCLES = `ADC_CONV_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    input wire logic clock_enable,
    // Avalon-MM slave
    input wire logic [31:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Interrupt
    output logic irq,
    // Analog core
    output adc_pkg::core_ctrl_t core_ctrl,
    input wire logic [DATA_WIDTH-1:0] core_data
);
    import adc_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    conv_state_t state_q;
    ctrl_t ctrl_q;
    logic eoc_q;
    logic [2:0] chan_q;
    logic [2:0] cnt_q;
    logic [DATA_WIDTH-1:0] result_q;
    logic wait_q;
    logic [31:0] rdata_q;
    core_ctrl_t core_q;
    logic tick;
    logic [0:0] irq_status;
    logic [0:0] irq_enable;
    logic irq_q;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire req = read || write;
    wire accept = req && !wait_q;
    wire hit_ctrl = (address == `ADC_CONTROL_ADDR);
    wire hit_result = (address == `ADC_RESULT_ADDR);
    wire hit_status = (address == `ADC_IRQ_STATUS_ADDR);
    wire hit_enable = (address == `ADC_IRQ_ENABLE_ADDR);
    wire hit_clear = (address == `ADC_IRQ_CLEAR_ADDR);
    wire wr_ctrl = accept && write && hit_ctrl;
    wire wr_lo = wr_ctrl && byteenable[0];
    wire wr_hi = wr_ctrl && byteenable[1];
    wire rd_result = accept && read && hit_result;
    wire busy = (state_q == CONV_RUN);

    wire start_write = wr_lo && writedata[`ADC_START_BIT];
    wire start_read = rd_result && ctrl_q.read_start;
    wire start = (start_write || start_read) && !busy && !ctrl_q.standby;
    wire done = busy && tick && (cnt_q == 3'(CONV_CYCLES - 1));
    // Channel for a starting conversion; a start write brings its own
    wire [2:0] start_channel = wr_lo ? writedata[5:3] : ctrl_q.channel;

    // Control readback
    wire [15:0] ctrl_rd = {eoc_q, ctrl_q.presc_enable, ctrl_q.presc_value, ctrl_q.channel,
        ctrl_q.standby, ctrl_q.read_start, busy};

    wire [31:0] rdata_d =
        hit_ctrl ? {16'h0000, ctrl_rd} :
        hit_result ? {{(32 - DATA_WIDTH){1'b0}}, result_q} :
        hit_status ? {31'h0000_0000, irq_status} :
        hit_enable ? {31'h0000_0000, irq_enable} :
        32'h0000_0000;

    // ------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            wait_q <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end
        else if (clock_enable)
        begin
            wait_q <= !(req && wait_q);
            if (req && wait_q)
                rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            ctrl_q.presc_enable <= 1'(`ADC_CONTROL_RESET >> `ADC_PRESC_ENABLE_BIT);
            ctrl_q.presc_value <= `ADC_PRESC_RESET;
            ctrl_q.channel <= 3'h0;
            ctrl_q.standby <= `ADC_STANDBY_RESET;
            ctrl_q.read_start <= 1'b0;
        end
        else if (clock_enable)
        begin
            if (wr_lo)
            begin
                ctrl_q.presc_value[1:0] <= writedata[7:6];
                ctrl_q.channel <= writedata[5:3];
                ctrl_q.standby <= writedata[`ADC_STANDBY_BIT];
                ctrl_q.read_start <= writedata[`ADC_READ_START_BIT];
            end
            if (wr_hi)
            begin
                ctrl_q.presc_value[7:2] <= writedata[13:8];
                ctrl_q.presc_enable <= writedata[`ADC_PRESC_ENABLE_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // Conversion sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            state_q <= CONV_IDLE;
            eoc_q <= 1'b0;
            chan_q <= 3'h0;
            cnt_q <= 3'h0;
            result_q <= '0;
        end
        else if (clock_enable)
        begin
            case (state_q)
                CONV_IDLE:
                begin
                    if (start)
                    begin
                        state_q <= CONV_RUN;
                        eoc_q <= 1'b0;
                        chan_q <= start_channel;
                        cnt_q <= 3'h0;
                    end
                end
                CONV_RUN:
                begin
                    // Standby aborts; result keeps its old value
                    if (ctrl_q.standby)
                        state_q <= CONV_IDLE;
                    else if (done)
                    begin
                        state_q <= CONV_IDLE;
                        eoc_q <= 1'b1;
                        result_q <= core_data;
                    end
                    else if (tick)
                        cnt_q <= cnt_q + 3'h1;
                end
                default:
                    state_q <= CONV_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Core outputs
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            core_q <= '{sample: 1'b0, busy: 1'b0, standby: 1'b1, tick: 1'b0, channel: 3'h0};
        else if (clock_enable)
        begin
            core_q.sample <= start;
            core_q.busy <= start || (busy && !done && !ctrl_q.standby);
            core_q.standby <= ctrl_q.standby;
            // Ticks only inside a conversion, so the core sees exactly five unless standby aborts it
            core_q.tick <= tick && busy && !ctrl_q.standby;
            core_q.channel <= start ? start_channel : chan_q;
        end
    end

    // ------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------
    adc_prescaler #(
        .WIDTH(8)
    ) u_prescaler (
        .clock(clock),
        .reset(reset),
        .clock_enable(clock_enable),
        .enable(ctrl_q.presc_enable),
        .value(ctrl_q.presc_value),
        .tick_q(tick)
    );

    adc_irq #(
        .N(1)
    ) u_irq (
        .clock(clock),
        .reset(reset),
        .clock_enable(clock_enable),
        .event_set(done),
        .enable_we(accept && write && hit_enable),
        .clear_we(accept && write && hit_clear),
        .wdata(writedata[`ADC_IRQ_EOC_BIT]),
        .status_q(irq_status),
        .enable_q(irq_enable),
        .irq_q(irq_q)
    );

    assign readdata = rdata_q;
    assign waitrequest = wait_q;
    assign irq = irq_q;
    assign core_ctrl = core_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    logic [2:0] ticks_seen_q;
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            ticks_seen_q <= 3'h0;
        else if (clock_enable)
            ticks_seen_q <= start ? 3'h0 : ticks_seen_q + 3'((busy && tick) ? 1 : 0);
    end

    AST_WRITE_STARTS: assert property (clock_enable && start_write && !busy
        && !ctrl_q.standby |=> busy)
        else $error("start write did not begin conversion");
    AST_ZERO_NO_START: assert property (clock_enable && !busy && !start_read
        && !(wr_lo && writedata[0]) |=> !busy)
        else $error("conversion began without a start");
    AST_SAMPLE_PULSE: assert property (clock_enable && core_ctrl.sample
        |=> !core_ctrl.sample)
        else $error("sample pulse longer than one cycle");
    AST_BUSY_READBACK: assert property (clock_enable && accept && read && hit_ctrl
        |-> readdata[0] == $past(busy))
        else $error("start bit readback wrong");
    AST_EOC_ON_DONE: assert property (clock_enable && done |=> eoc_q && !busy)
        else $error("end flag not set on completion");
    AST_EOC_HOLDS: assert property (clock_enable && eoc_q && !start |=> eoc_q)
        else $error("end flag lost without a start");
    AST_START_CLEARS_EOC: assert property (clock_enable && start |=> busy && !eoc_q)
        else $error("start did not clear end flag");
    AST_RESULT_LOAD: assert property (clock_enable && done
        |=> result_q == $past(core_data))
        else $error("result not loaded");
    AST_RESULT_KEPT: assert property (clock_enable && !done |=> $stable(result_q))
        else $error("result changed without completion");
    AST_READ_START: assert property (clock_enable && rd_result && ctrl_q.read_start
        && !busy && !ctrl_q.standby |=> busy)
        else $error("result read did not start conversion");
    AST_READ_NO_START: assert property (clock_enable && rd_result && !ctrl_q.read_start
        && !busy && !wr_lo |=> !busy)
        else $error("result read started conversion");
    AST_STANDBY_HALT: assert property (clock_enable && ctrl_q.standby
        |=> !busy && $stable(result_q))
        else $error("activity in standby");
    AST_CTRL_WRITE: assert property (clock_enable && wr_lo
        |=> ctrl_q.channel == $past(writedata[5:3]) && ctrl_q.standby == $past(writedata[2]))
        else $error("control low byte not stored");
    AST_PRESC_WRITE: assert property (clock_enable && wr_hi
        |=> {ctrl_q.presc_enable, ctrl_q.presc_value[7:2]} == $past(writedata[14:8]))
        else $error("control high byte not stored");
    AST_FIVE_TICKS: assert property (done |-> ticks_seen_q == 3'(CONV_CYCLES - 1))
        else $error("conversion length wrong");
    AST_CHANNEL_HELD: assert property (busy && $past(busy) && $past(clock_enable)
        |-> $stable(chan_q) && core_ctrl.channel == chan_q)
        else $error("channel changed during conversion");
    AST_CORE_CHANNEL_START: assert property (clock_enable && start
        |=> core_ctrl.sample && core_ctrl.channel == chan_q)
        else $error("core channel wrong at start");
    AST_IRQ_FOLLOWS: assert property (clock_enable
        |=> irq == (irq_status[0] && irq_enable[0]))
        else $error("interrupt level wrong");

    // ------------------------------------------------------------
    // Coverage
    // ------------------------------------------------------------
    COV_WRITE_CONVERT: cover property (start_write ##[1:1000] done);
    COV_READ_CONVERT: cover property (start_read ##[1:1000] done);
    COV_STANDBY_ABORT: cover property (busy && ctrl_q.standby);
    COV_IRQ: cover property ($rose(irq));
    COV_FROZEN: cover property (busy && !clock_enable);
endmodule
`default_nettype wire

// ==== adc_core_model.sv ====
// Purpose: Behavioural analog core facing the converter control.
// Assumes: Result is sampled on the control clock while busy.
// Notes: Data toggles outside a conversion, so stale values never match.
`timescale 1ns/1ps
`default_nettype none
module adc_core_model (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Core side
    input wire adc_pkg::core_ctrl_t core_ctrl,
    output logic [9:0] core_data
);
    import adc_pkg::*;
    logic [6:0] seq_q;
    logic [9:0] last_q;
    wire logic [9:0] live = {core_ctrl.channel, seq_q};
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            seq_q <= 7'h00;
            last_q <= 10'h000;
        end
        else
        begin
            if (core_ctrl.sample)
                seq_q <= seq_q + 7'h01;
            last_q <= core_data;
        end
    end
    // Live channel, so a moved channel shows in the result
    assign core_data = core_ctrl.busy ? live : ~last_q;
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Purpose: Register-level tests of the converter control.
// Assumes: One wait state per access; bus driven on rising edges.
// Notes: Core model returns channel and start count.
`timescale 1ns/1ps
`default_nettype none
`include "adc_cfg.svh"
module tb_top;
    import adc_pkg::*;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [31:0] address = 32'h0;
    logic [31:0] writedata = 32'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [3:0] byteenable = 4'hf;
    logic [31:0] readdata;
    logic waitrequest;
    logic irq;
    core_ctrl_t core_ctrl;
    logic [9:0] core_data;
    logic [31:0] rd;
    logic [31:0] keep;
    logic tick_on = 1'b0;
    logic clock_enable = 1'b1;
    int fails = 0;
    int cmp_count = 0;
    int seq = 0;
    int presc = 9;
    int gap = 0;
    int ticks = 0;

    always #20 clock = ~clock;

    adc_conversion_control u_dut (.clock(clock), .reset(reset), .clock_enable(clock_enable),
        .address(address), .read(read), .write(write), .writedata(writedata),
        .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
        .irq(irq), .core_ctrl(core_ctrl), .core_data(core_data));
    adc_core_model u_core (.clock(clock), .reset(reset), .core_ctrl(core_ctrl),
        .core_data(core_data));

    // --------
    // Tasks
    // --------
    task complete_run;
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task access(input logic wr, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        address <= a;
        writedata <= d;
        read <= !wr;
        write <= wr;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (waitrequest !== 1'b0 && n < 50);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (waitrequest !== 1'b0)
        begin
            fails++;
            complete_run;
        end
    endtask

    function automatic logic [31:0] cw(input int v, input logic [2:0] ch,
        input logic sb, input logic rs, input logic st);
        return {17'h0, 1'b1, v[7:0], ch, sb, rs, st};
    endfunction

    task wait_eoc;
        int n;
        n = 0;
        do
        begin
            access(1'b0, `ADC_CONTROL_ADDR, 32'h0);
            n++;
        end
        while (rd[15] !== 1'b1 && n < 200);
        if (rd[15] !== 1'b1)
        begin
            fails++;
            complete_run;
        end
    endtask

    task run(input logic [2:0] ch);
        access(1'b1, `ADC_CONTROL_ADDR, cw(presc, ch, 1'b0, 1'b0, 1'b1));
        seq++;
        access(1'b0, `ADC_CONTROL_ADDR, 32'h0);
        check("busy bit", rd[0], 1'b1);
        wait_eoc;
        check("done bit", rd[0], 1'b0);
        access(1'b0, `ADC_RESULT_ADDR, 32'h0);
        check("result", rd, {22'h0, ch, seq[6:0]});
    endtask

    // Tick spacing and count per conversion
    always @(posedge clock)
    begin
        gap++;
        if (core_ctrl.tick)
        begin
            if (tick_on && ticks != 0)
                check("tick gap", gap, presc + 1);
            ticks++;
            gap = 0;
        end
        else if (!core_ctrl.busy && ticks != 0)
        begin
            if (tick_on)
                check("ticks", ticks, 5);
            ticks = 0;
        end
    end

    initial
    begin
        repeat (5) @(posedge clock);
        reset <= 1'b0;
        access(1'b0, `ADC_CONTROL_ADDR, 32'h0);
        check("ctrl reset", rd, 32'h3fc4);
        access(1'b0, `ADC_RESULT_ADDR, 32'h0);
        check("result reset", rd, 32'h0);
        access(1'b0, 32'h1580_0020, 32'h0);
        check("unmapped", rd, 32'h0);
        access(1'b1, `ADC_CONTROL_ADDR, 32'h3fc5);
        access(1'b0, `ADC_CONTROL_ADDR, 32'h0);
        check("standby start", rd, 32'h3fc4);
        access(1'b1, `ADC_CONTROL_ADDR, cw(presc, 3'h2, 1'b0, 1'b0, 1'b0));
        access(1'b0, `ADC_CONTROL_ADDR, 32'h0);
        check("zero start", rd, cw(presc, 3'h2, 1'b0, 1'b0, 1'b0));
        tick_on = 1'b1;
        run(3'h5);
        access(1'b0, `ADC_IRQ_STATUS_ADDR, 32'h0);
        check("status", rd, 32'h1);
        check("irq masked", irq, 1'b0);
        access(1'b1, `ADC_IRQ_ENABLE_ADDR, 32'h1);
        repeat (2) @(posedge clock);
        #1;
        check("irq on", irq, 1'b1);
        access(1'b1, `ADC_IRQ_CLEAR_ADDR, 32'h1);
        access(1'b0, `ADC_IRQ_STATUS_ADDR, 32'h0);
        check("cleared", rd, 32'h0);
        check("irq off", irq, 1'b0);
        for (int c = 0; c < 8; c++)
            run(c[2:0]);
        check("irq raised", irq, 1'b1);
        access(1'b1, `ADC_IRQ_CLEAR_ADDR, 32'h1);
        access(1'b1, `ADC_CONTROL_ADDR, cw(presc, 3'h1, 1'b0, 1'b0, 1'b1));
        seq++;
        access(1'b1, `ADC_CONTROL_ADDR, cw(presc, 3'h6, 1'b0, 1'b0, 1'b0));
        wait_eoc;
        access(1'b0, `ADC_RESULT_ADDR, 32'h0);
        check("held channel", rd, {22'h0, 3'h1, seq[6:0]});
        presc = 20;
        run(3'h7);
        access(1'b1, `ADC_CONTROL_ADDR, cw(presc, 3'h4, 1'b0, 1'b1, 1'b0));
        access(1'b0, `ADC_RESULT_ADDR, 32'h0);
        seq++;
        access(1'b0, `ADC_CONTROL_ADDR, 32'h0);
        check("read start", rd[0], 1'b1);
        wait_eoc;
        access(1'b0, `ADC_RESULT_ADDR, 32'h0);
        check("read result", rd, {22'h0, 3'h4, seq[6:0]});
        seq++;
        access(1'b1, `ADC_CONTROL_ADDR, cw(presc, 3'h4, 1'b0, 1'b0, 1'b0));
        wait_eoc;
        access(1'b0, `ADC_RESULT_ADDR, 32'h0);
        check("last chained", rd, {22'h0, 3'h4, seq[6:0]});
        access(1'b0, `ADC_CONTROL_ADDR, 32'h0);
        check("no read start", rd[0], 1'b0);
        tick_on = 1'b0;
        access(1'b1, `ADC_CONTROL_ADDR, cw(presc, 3'h3, 1'b0, 1'b0, 1'b1));
        seq++;
        repeat (3) @(posedge clock);
        clock_enable <= 1'b0;
        repeat (150) @(posedge clock);
        check("frozen busy", core_ctrl.busy, 1'b1);
        clock_enable <= 1'b1;
        wait_eoc;
        access(1'b0, `ADC_RESULT_ADDR, 32'h0);
        keep = rd;
        check("frozen result", rd, {22'h0, 3'h3, seq[6:0]});
        access(1'b1, `ADC_CONTROL_ADDR, cw(presc, 3'h2, 1'b0, 1'b0, 1'b1));
        repeat (20) @(posedge clock);
        access(1'b1, `ADC_CONTROL_ADDR, cw(presc, 3'h2, 1'b1, 1'b0, 1'b0));
        access(1'b0, `ADC_CONTROL_ADDR, 32'h0);
        check("standby readback", rd[2:0], 3'h4);
        repeat (200) @(posedge clock);
        check("halted", core_ctrl.busy, 1'b0);
        access(1'b0, `ADC_RESULT_ADDR, 32'h0);
        check("kept result", rd, keep);
        complete_run;
    end
endmodule
`default_nettype wire
